// File: pcd_regs.vh
// Purpose : Register offsets, field positions and reset values for the
//           pin change edge detector.
// Assumes : AHB-Lite register bus with 32-bit data, one word per register.
// Notes   : Definitions only; included by bare name from the design files.
//
// Behaviour
// - Any pin combination may be a change source.
// - Every pin has rising and falling detectors.
// - Interrupt forwarded only with master enable set.
// - Master clear: detect edges, raise no interrupt.
// - Rising edge sensed only if rising bit set.
// - Falling edge sensed only if falling bit set.
// - Both bits set: either direction is an edge.
// - Enabled edge sets flag; interrupt needs master enable.
// - Summary flag shows any change flag set.
// - Write zero clears flag; concurrent edge wins.
// - Enabled edge wakes sleep; flags updated first. Wake here also needs master enable.

`ifndef PCD_REGS_VH
`define PCD_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCD_OFS_CTRL        8'h00
`define PCD_OFS_G1_RISE     8'h04
`define PCD_OFS_G1_FALL     8'h08
`define PCD_OFS_G1_FLAG     8'h0C
`define PCD_OFS_G2_RISE     8'h10
`define PCD_OFS_G2_FALL     8'h14
`define PCD_OFS_G2_FLAG     8'h18
`define PCD_OFS_IRQ_STAT    8'h1C
`define PCD_OFS_IRQ_CLR     8'h20
`define PCD_OFS_IRQ_EN      8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCD_CTRL_MASTER_BIT 0
`define PCD_CTRL_SUMMARY_BIT 1
`define PCD_IRQ_G1_BIT      0
`define PCD_IRQ_G2_BIT      1
`define PCD_IRQ_WIDTH       2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCD_RST_MASTER      1'b0
`define PCD_RST_IRQ         2'h0
`define PCD_RST_WORD        32'h0000_0000

`endif

// File: pcd_edge_detect.v
// Purpose : Synchronise a group of pins and report level changes per pin.
// Assumes : Pins are asynchronous to clk_i.
// Notes   : Outputs are one-cycle pulses, combinational from flip-flops.
`timescale 1ns/1ps

module pcd_edge_detect
#(
    parameter WIDTH = 8
)
(
    // Clock and reset.
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Pin levels from outside.
    input  wire [WIDTH-1:0] pin_i,
    // Change pulses.
    output wire [WIDTH-1:0] rise_o,
    output wire [WIDTH-1:0] fall_o
);

    genvar g;

    // ------------------------------------------------------------------
    // Per-pin synchroniser and edge detector
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : pin_gen
            reg s1_ff;     // First stage, read only by the second stage.
            reg s2_ff;     // Second stage.
            reg s3_ff;     // Third stage.
            reg lvl_ff;    // Last accepted level.
            reg primed_ff; // High once a first level has been accepted.
            reg [2:0] fill_ff; // Stages that already hold a real pin sample.
            wire agree;    // Second and third stages hold the same level.

            assign agree = (s2_ff == s3_ff);

            // Shift the pin through three stages and keep an accepted level.
            // No level is accepted until the third stage holds a real pin
            // sample, and that first level is never an edge, so a pin that
            // idles high does not look like a rising edge after reset.
            always @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    s1_ff     <= 1'b0;
                    s2_ff     <= 1'b0;
                    s3_ff     <= 1'b0;
                    lvl_ff    <= 1'b0;
                    primed_ff <= 1'b0;
                    fill_ff   <= 3'b000;
                end
                else
                begin
                    s1_ff <= pin_i[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    fill_ff <= {fill_ff[1:0], 1'b1};
                    if (agree && fill_ff[2])
                    begin
                        lvl_ff    <= s3_ff;
                        primed_ff <= 1'b1;
                    end
                end
            end

            // A change is the agreed sample differing from the stored one.
            assign rise_o[g] = primed_ff & agree & s3_ff & ~lvl_ff;
            assign fall_o[g] = primed_ff & agree & ~s3_ff & lvl_ff;
        end
    endgenerate

endmodule

// File: pcd_pin_change.v
// Purpose : Pin change interrupt block for two pin groups, with AHB-Lite
//           register access, sticky event status and sleep wake-up.
// Assumes : Single clock clk_i at 200 MHz; reset rst_n_i asynchronous low.
// Notes   : Every bus access takes one wait state; all outputs are flops.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pcd_regs.vh"

module pcd_pin_change
#(
    parameter G1_WIDTH = 8,
    parameter G2_WIDTH = 8
)
(
    // Clock and reset.
    input  wire                clk_i,
    input  wire                rst_n_i,
    // AHB-Lite slave port.
    input  wire                hsel_i,
    input  wire [7:0]          haddr_i,
    input  wire [1:0]          htrans_i,
    input  wire                hwrite_i,
    input  wire [2:0]          hsize_i,
    input  wire                hready_i,
    input  wire [31:0]         hwdata_i,
    output reg  [31:0]         hrdata_o,
    output reg                 hreadyout_o,
    output reg                 hresp_o,
    // Pin groups.
    input  wire [G1_WIDTH-1:0] first_pin_group_i,
    input  wire [G2_WIDTH-1:0] second_pin_group_i,
    // Power state and interrupt.
    input  wire                sleep_i,
    output reg                 wake_o,
    output reg                 irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Bus transfer tracking.
    reg                  pend_ff;       // A data phase is in progress.
    reg  [7:0]           addr_ff;       // Captured address.
    reg                  write_ff;      // Captured direction.
    reg  [31:0]          nxt_rdata;     // Read value for the captured address.
    wire                 take;          // Address phase accepted this edge.
    wire                 wr_now;        // Write data phase completes now.

    // Control and configuration.
    reg                  change_master_enable_ff;
    reg  [G1_WIDTH-1:0]  g1_rise_en_ff;  // rising_edge_enable_reg, group one.
    reg  [G1_WIDTH-1:0]  g1_fall_en_ff;  // falling_edge_enable_reg, group one.
    reg  [G2_WIDTH-1:0]  g2_rise_en_ff;  // rising_edge_enable_reg, group two.
    reg  [G2_WIDTH-1:0]  g2_fall_en_ff;  // falling_edge_enable_reg, group two.

    // Change flags.
    reg  [G1_WIDTH-1:0]  group_one_change_flag_ff;
    reg  [G2_WIDTH-1:0]  group_two_change_flag_ff;
    reg  [G1_WIDTH-1:0]  nxt_g1_flag;
    reg  [G2_WIDTH-1:0]  nxt_g2_flag;

    // Sticky event status and its enable.
    reg  [`PCD_IRQ_WIDTH-1:0] irq_stat_ff;
    reg  [`PCD_IRQ_WIDTH-1:0] irq_en_ff;
    reg  [`PCD_IRQ_WIDTH-1:0] nxt_irq_stat;
    wire [`PCD_IRQ_WIDTH-1:0] irq_event;

    // Edge detector results.
    wire [G1_WIDTH-1:0]  g1_rise;
    wire [G1_WIDTH-1:0]  g1_fall;
    wire [G2_WIDTH-1:0]  g2_rise;
    wire [G2_WIDTH-1:0]  g2_fall;
    wire [G1_WIDTH-1:0]  g1_edge;       // Enabled edges, group one.
    wire [G2_WIDTH-1:0]  g2_edge;       // Enabled edges, group two.
    wire                 change_summary_flag;
    wire                 any_edge;

    // ------------------------------------------------------------------
    // Edge detectors
    // ------------------------------------------------------------------
    // Each group has its own synchroniser and detector bank.
    pcd_edge_detect
    #(
        .WIDTH (G1_WIDTH)
    )
    u_g1_det
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (first_pin_group_i),
        .rise_o  (g1_rise),
        .fall_o  (g1_fall)
    );

    pcd_edge_detect
    #(
        .WIDTH (G2_WIDTH)
    )
    u_g2_det
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (second_pin_group_i),
        .rise_o  (g2_rise),
        .fall_o  (g2_fall)
    );

    // ------------------------------------------------------------------
    // Edge qualification
    // ------------------------------------------------------------------
    // A pin reports an edge only in a direction that is enabled for it;
    // with both directions enabled either change counts. Each pin is
    // independent, so any combination may act as a source.
    assign g1_edge = (g1_rise & g1_rise_en_ff) | (g1_fall & g1_fall_en_ff);
    assign g2_edge = (g2_rise & g2_rise_en_ff) | (g2_fall & g2_fall_en_ff);

    // Summary of all individual flags of both groups.
    assign change_summary_flag = (|group_one_change_flag_ff) |
                                 (|group_two_change_flag_ff);

    // Any enabled edge this cycle, used for wake-up.
    assign any_edge = (|g1_edge) | (|g2_edge);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // A transfer is taken on a NONSEQ or SEQ address phase while the bus
    // is ready; the data phase then always inserts one wait state.
    assign take   = hsel_i & htrans_i[1] & hready_i;
    assign wr_now = pend_ff & write_ff;

    // Capture the address phase and run the one-wait data phase.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_ff     <= 1'b0;
            addr_ff     <= 8'h00;
            write_ff    <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= `PCD_RST_WORD;
        end
        else if (pend_ff)
        begin
            // Data phase ends: present read data and release ready.
            pend_ff     <= 1'b0;
            hreadyout_o <= 1'b1;
            hrdata_o    <= write_ff ? `PCD_RST_WORD : nxt_rdata;
        end
        else if (take)
        begin
            // Address phase accepted: hold ready low for one cycle.
            pend_ff     <= 1'b1;
            addr_ff     <= {haddr_i[7:2], 2'b00};
            write_ff    <= hwrite_i;
            hreadyout_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Unused upper bits and unmapped addresses read as zero.
    always @*
    begin
        nxt_rdata = `PCD_RST_WORD;
        case (addr_ff)
            `PCD_OFS_CTRL:
            begin
                nxt_rdata[`PCD_CTRL_MASTER_BIT]  = change_master_enable_ff;
                nxt_rdata[`PCD_CTRL_SUMMARY_BIT] = change_summary_flag;
            end
            `PCD_OFS_G1_RISE: nxt_rdata[G1_WIDTH-1:0] = g1_rise_en_ff;
            `PCD_OFS_G1_FALL: nxt_rdata[G1_WIDTH-1:0] = g1_fall_en_ff;
            `PCD_OFS_G1_FLAG: nxt_rdata[G1_WIDTH-1:0] = group_one_change_flag_ff;
            `PCD_OFS_G2_RISE: nxt_rdata[G2_WIDTH-1:0] = g2_rise_en_ff;
            `PCD_OFS_G2_FALL: nxt_rdata[G2_WIDTH-1:0] = g2_fall_en_ff;
            `PCD_OFS_G2_FLAG: nxt_rdata[G2_WIDTH-1:0] = group_two_change_flag_ff;
            `PCD_OFS_IRQ_STAT: nxt_rdata[`PCD_IRQ_WIDTH-1:0] = irq_stat_ff;
            `PCD_OFS_IRQ_EN:   nxt_rdata[`PCD_IRQ_WIDTH-1:0] = irq_en_ff;
            default:          nxt_rdata = `PCD_RST_WORD;
        endcase
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Software-written control; the summary bit is read-only.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            change_master_enable_ff <= `PCD_RST_MASTER;
            g1_rise_en_ff           <= {G1_WIDTH{1'b0}};
            g1_fall_en_ff           <= {G1_WIDTH{1'b0}};
            g2_rise_en_ff           <= {G2_WIDTH{1'b0}};
            g2_fall_en_ff           <= {G2_WIDTH{1'b0}};
            irq_en_ff               <= `PCD_RST_IRQ;
        end
        else if (wr_now)
        begin
            case (addr_ff)
                `PCD_OFS_CTRL:
                    change_master_enable_ff <= hwdata_i[`PCD_CTRL_MASTER_BIT];
                `PCD_OFS_G1_RISE: g1_rise_en_ff <= hwdata_i[G1_WIDTH-1:0];
                `PCD_OFS_G1_FALL: g1_fall_en_ff <= hwdata_i[G1_WIDTH-1:0];
                `PCD_OFS_G2_RISE: g2_rise_en_ff <= hwdata_i[G2_WIDTH-1:0];
                `PCD_OFS_G2_FALL: g2_fall_en_ff <= hwdata_i[G2_WIDTH-1:0];
                `PCD_OFS_IRQ_EN:  irq_en_ff <= hwdata_i[`PCD_IRQ_WIDTH-1:0];
                default:
                begin
                    // Other addresses leave configuration untouched.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Change flags
    // ------------------------------------------------------------------
    // A write keeps only the bits written as one, so writing zero clears a
    // flag; an enabled edge in the same cycle sets it regardless.
    always @*
    begin
        nxt_g1_flag = group_one_change_flag_ff;
        nxt_g2_flag = group_two_change_flag_ff;
        if (wr_now && (addr_ff == `PCD_OFS_G1_FLAG))
        begin
            nxt_g1_flag = group_one_change_flag_ff & hwdata_i[G1_WIDTH-1:0];
        end
        if (wr_now && (addr_ff == `PCD_OFS_G2_FLAG))
        begin
            nxt_g2_flag = group_two_change_flag_ff & hwdata_i[G2_WIDTH-1:0];
        end
        // Detection runs whatever the master enable says.
        nxt_g1_flag = nxt_g1_flag | g1_edge;
        nxt_g2_flag = nxt_g2_flag | g2_edge;
    end

    // Store the flags.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            group_one_change_flag_ff <= {G1_WIDTH{1'b0}};
            group_two_change_flag_ff <= {G2_WIDTH{1'b0}};
        end
        else
        begin
            group_one_change_flag_ff <= nxt_g1_flag;
            group_two_change_flag_ff <= nxt_g2_flag;
        end
    end

    // ------------------------------------------------------------------
    // Sticky event status
    // ------------------------------------------------------------------
    // One event bit per group: any enabled edge in that group.
    assign irq_event[`PCD_IRQ_G1_BIT] = |g1_edge;
    assign irq_event[`PCD_IRQ_G2_BIT] = |g2_edge;

    // Clear by writing ones to the clear register; a new event wins.
    always @*
    begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_now && (addr_ff == `PCD_OFS_IRQ_CLR))
        begin
            nxt_irq_stat = irq_stat_ff & ~hwdata_i[`PCD_IRQ_WIDTH-1:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_event;
    end

    // Store the status.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_ff <= `PCD_RST_IRQ;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and wake-up outputs
    // ------------------------------------------------------------------
    // The interrupt is held while the master enable is set and either a
    // change flag or an enabled status bit is set. With the master enable
    // clear nothing caused by an edge reaches the output. Wake-up pulses
    // one cycle after the edge, when the flags already hold it.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o  <= change_master_enable_ff &
                      ((|(nxt_g1_flag)) | (|(nxt_g2_flag)) |
                       (|(nxt_irq_stat & irq_en_ff)));
            wake_o <= change_master_enable_ff & sleep_i & any_edge;
        end
    end

endmodule

// File: pcd_pin_drv.sv
// Purpose : Outside world driving the two pin groups.
// Assumes : Pins change just after a rising edge.
// Notes   : Levels are held until the bench asks for new ones.
`timescale 1ns/1ps

module pcd_pin_drv
(
    // Clock.
    input  logic       clk_i,
    // Pin levels.
    output logic [7:0] first_pin_group_o,
    output logic [7:0] second_pin_group_o
);
    // Pins start low so the first agreed level is not an edge.
    initial
    begin
        first_pin_group_o = 8'h00;
        second_pin_group_o = 8'h00;
    end

    // Sets both groups after the next edge; pins are asynchronous.
    task drive(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_i);
        first_pin_group_o <= a;
        second_pin_group_o <= b;
    endtask
endmodule

// File: pcd_pin_change_asserts.sv
// Purpose : Port checks for the pin change block.
// Assumes : One clock, reset asynchronous low.
// Notes   : Attached to every instance by the bind at the foot.
`timescale 1ns/1ps

module pcd_pin_change_asserts
#(
    parameter G1_WIDTH = 8,
    parameter G2_WIDTH = 8
)
(
    // Clock, reset and bus.
    input logic                clk_i,
    input logic                rst_n_i,
    input logic                hsel_i,
    input logic [7:0]          haddr_i,
    input logic [1:0]          htrans_i,
    input logic                hwrite_i,
    input logic [2:0]          hsize_i,
    input logic                hready_i,
    input logic [31:0]         hwdata_i,
    input logic [31:0]         hrdata_o,
    input logic                hreadyout_o,
    input logic                hresp_o,
    // Pins, sleep and interrupt.
    input logic [G1_WIDTH-1:0] first_pin_group_i,
    input logic [G2_WIDTH-1:0] second_pin_group_i,
    input logic                sleep_i,
    input logic                wake_o,
    input logic                irq_o
);
    // ----------------------------------------
    // Helper ages
    // ----------------------------------------
    logic [G1_WIDTH+G2_WIDTH-1:0] pin_q_ff;   // Pins one cycle ago.
    logic [3:0]                   pin_age_ff; // Cycles since pins moved.
    logic                         wr_ph_ff;   // Write data phase running.
    logic [3:0]                   wr_age_ff;  // Cycles since a write ended.
    wire take = hsel_i & htrans_i[1] & hready_i;

    // Ages saturate at 15 so an old cause never looks recent.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_q_ff <= '0;
            pin_age_ff <= 4'hF;
            wr_ph_ff <= 1'b0;
            wr_age_ff <= 4'hF;
        end
        else
        begin
            pin_q_ff <= {first_pin_group_i, second_pin_group_i};
            if (pin_q_ff != {first_pin_group_i, second_pin_group_i})
                pin_age_ff <= 4'h0;
            else if (pin_age_ff != 4'hF)
                pin_age_ff <= pin_age_ff + 4'h1;
            wr_ph_ff <= take & hwrite_i;
            if (wr_ph_ff)
                wr_age_ff <= 4'h0;
            else if (wr_age_ff != 4'hF)
                wr_age_ff <= wr_age_ff + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_wait_state: assert property (take |=> !hreadyout_o ##1 hreadyout_o)
        else $error("bus wait state is not exactly one cycle");
    chk_ready_pulse: assert property (!hreadyout_o |=> hreadyout_o)
        else $error("hreadyout stays low");
    chk_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    chk_write_zero: assert property (take && hwrite_i |=> ##1 hrdata_o == 32'h0000_0000)
        else $error("read data not zero after write");
    chk_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
        else $error("read data moved between transfers");
    chk_irq_cause: assert property ($rose(irq_o) |->
        (pin_age_ff >= 4'h2 && pin_age_ff <= 4'h6) || wr_age_ff <= 4'h3)
        else $error("interrupt rose without a pin edge or write");
    chk_irq_sticky: assert property ($fell(irq_o) |-> wr_age_ff <= 4'h3)
        else $error("interrupt fell without a write");
    chk_wake_sleep: assert property (wake_o |-> $past(sleep_i) && irq_o)
        else $error("wake outside sleep or without interrupt");
    chk_wake_edge: assert property (wake_o |-> pin_age_ff >= 4'h2 && pin_age_ff <= 4'h6)
        else $error("wake not tied to a recent pin change");
endmodule

bind pcd_pin_change pcd_pin_change_asserts #(.G1_WIDTH(G1_WIDTH), .G2_WIDTH(G2_WIDTH)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .first_pin_group_i(first_pin_group_i),
    .second_pin_group_i(second_pin_group_i), .sleep_i(sleep_i), .wake_o(wake_o),
    .irq_o(irq_o));

// File: pcd_pin_change_tb.sv
// Purpose : Self-checking bench for the pin change block.
// Assumes : One bus slave, so hready is the slave's hreadyout.
// Notes   : Waits of 8 cycles cover pin sync, flag and interrupt.
`timescale 1ns/1ps
`include "pcd_regs.vh"

module pcd_pin_change_tb;
    logic        clk_i = 1'b0;            // 200 MHz clock.
    logic        rst_n_i = 1'b0;          // Reset, active low.
    logic        hsel_i = 1'b0;           // Bus select.
    logic [7:0]  haddr_i = 8'h00;         // Bus address.
    logic [1:0]  htrans_i = 2'h0;         // Bus transfer type.
    logic        hwrite_i = 1'b0;         // Bus direction.
    logic [2:0]  hsize_i = 3'h2;          // Always a word.
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic        sleep_i = 1'b0;          // Core asleep.
    wire  [31:0] hrdata_o;
    wire         hreadyout_o;
    wire         hresp_o;
    wire         wake_o;
    wire         irq_o;
    wire  [7:0]  g1;                      // Group one pins.
    wire  [7:0]  g2;                      // Group two pins.
    logic [31:0] rd;                      // Last read word.
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          n_wake = 0;              // Wake pulses seen.

    always #2.5 clk_i = ~clk_i;

    pcd_pin_drv drv (.clk_i(clk_i), .first_pin_group_o(g1), .second_pin_group_o(g2));

    pcd_pin_change dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .first_pin_group_i(g1),
        .second_pin_group_i(g2), .sleep_i(sleep_i), .wake_o(wake_o), .irq_o(irq_o));

    // Counts each cycle that the wake pulse is high.
    always @(posedge clk_i)
        if (wake_o === 1'b1)
            n_wake++;

    // Compares one value and reports a difference at once.
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One single transfer: address phase, then data phase until hready.
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    // Lets a pin change or a write reach the flags and the interrupt.
    task settle;
        repeat (8) @(posedge clk_i);
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Cuts a hang short; the tests need far fewer cycles.
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict;
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Every register and one unmapped word read zero after reset.
        for (int i = 0; i <= 'h28; i += 4)
            rdc("reset", i[7:0], 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        $display("test reset done");
        // Per-pin direction enables, both groups.
        wr(`PCD_OFS_G1_RISE, 32'h0000_000F);
        wr(`PCD_OFS_G1_FALL, 32'h0000_00F0);
        wr(`PCD_OFS_G2_RISE, 32'h0000_00AA);
        wr(`PCD_OFS_G2_FALL, 32'h0000_0055);
        drv.drive(8'hFF, 8'hFF);
        settle;
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_000F);
        rdc("g2 flag", `PCD_OFS_G2_FLAG, 32'h0000_00AA);
        rdc("ctrl", `PCD_OFS_CTRL, 32'h0000_0002);
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        wr(`PCD_OFS_G1_FLAG, 32'h0000_0000);
        wr(`PCD_OFS_G2_FLAG, 32'h0000_0000);
        drv.drive(8'h00, 8'h00);
        settle;
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_00F0);
        rdc("g2 flag", `PCD_OFS_G2_FLAG, 32'h0000_0055);
        rdc("status", `PCD_OFS_IRQ_STAT, 32'h0000_0003);
        $display("test directions done");
        // Master enable lets pending flags raise the interrupt.
        wr(`PCD_OFS_CTRL, 32'h0000_0001);
        settle;
        chk("irq", 32'h0000_0001, {31'h0, irq_o});
        rdc("ctrl", `PCD_OFS_CTRL, 32'h0000_0003);
        // Writing ones keeps a flag, writing zero clears it.
        wr(`PCD_OFS_G1_FLAG, 32'hFFFF_FF0F);
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_0000);
        wr(`PCD_OFS_G2_FLAG, 32'h0000_00FF);
        rdc("g2 flag", `PCD_OFS_G2_FLAG, 32'h0000_0055);
        wr(`PCD_OFS_G2_FLAG, 32'h0000_0000);
        settle;
        rdc("ctrl", `PCD_OFS_CTRL, 32'h0000_0001);
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        // Status interrupt: enable, mask, clear.
        wr(`PCD_OFS_IRQ_EN, 32'h0000_0001);
        settle;
        chk("irq", 32'h0000_0001, {31'h0, irq_o});
        wr(`PCD_OFS_IRQ_EN, 32'h0000_0000);
        settle;
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        wr(`PCD_OFS_IRQ_EN, 32'h0000_0003);
        wr(`PCD_OFS_IRQ_CLR, 32'h0000_0003);
        settle;
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        rdc("status", `PCD_OFS_IRQ_STAT, 32'h0000_0000);
        rdc("clear", `PCD_OFS_IRQ_CLR, 32'h0000_0000);
        $display("test clearing done");
        // Both directions on pin zero of group one.
        wr(`PCD_OFS_G1_FALL, 32'h0000_00FF);
        drv.drive(8'h01, 8'h00);
        settle;
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_0001);
        // The clearing write lands in the cycle of the falling edge.
        drv.drive(8'h00, 8'h00);
        @(posedge clk_i);
        wr(`PCD_OFS_G1_FLAG, 32'h0000_0000);
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_0001);
        wr(`PCD_OFS_G1_FLAG, 32'h0000_0000);
        wr(`PCD_OFS_IRQ_CLR, 32'h0000_0003);
        $display("test both edges done");
        // Sleep: wake only with the master enable set.
        sleep_i <= 1'b1;
        n_wake = 0;
        drv.drive(8'h02, 8'h00);
        settle;
        chk("wakes", 32'h0000_0001, n_wake);
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_0002);
        wr(`PCD_OFS_CTRL, 32'h0000_0000);
        wr(`PCD_OFS_G1_FLAG, 32'h0000_0000);
        wr(`PCD_OFS_IRQ_CLR, 32'h0000_0003);
        n_wake = 0;
        drv.drive(8'h00, 8'h00);
        settle;
        chk("wakes", 32'h0000_0000, n_wake);
        rdc("g1 flag", `PCD_OFS_G1_FLAG, 32'h0000_0002);
        sleep_i <= 1'b0;
        $display("test sleep done");
        print_verdict;
    end
endmodule
